// ===== sdi_regs.vh
// sdi_regs.vh: constants for the serial converter input logic
// assumes: included by the design files of the sdi block only
`ifndef SDI_REGS_VH
`define SDI_REGS_VH

`define SDI_FRAME_BITS 16
`define SDI_CNT_W 5
`define SDI_CODE_W 12
`define SDI_CODE_MSB 11
`define SDI_CODE_LSB 0
`define SDI_MODE_HI_POS 13
`define SDI_MODE_LO_POS 12
`define SDI_CODE_RESET 12'h000
`define SDI_MODE_RESET 2'h0
`define SDI_MODE_NORMAL 2'h0
`define SDI_MODE_GND_1K 2'h1
`define SDI_MODE_GND_100K 2'h2
`define SDI_MODE_HIZ 2'h3
`define SDI_CLK_PERIOD_PS 5000
`define SDI_SEL_HIGH_MIN_PS 33000
`define SDI_SEL_HIGH_CYC ((`SDI_SEL_HIGH_MIN_PS + `SDI_CLK_PERIOD_PS - 1) / `SDI_CLK_PERIOD_PS)
`define SDI_FIFO_W 14
`define SDI_FIFO_DEPTH 8
`define SDI_FIFO_AW 3

`endif

// ===== sdi_sync2.v
// sdi_sync2.v: two-flop synchroniser for a group of pin levels
// assumes: inputs are asynchronous to clk; first stage feeds only the second
`timescale 1ns/1ps
module sdi_sync2 #(
  parameter W = 3
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // levels
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta;

  always @(posedge clk) begin
    if (srst) begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ===== sdi_fifo.v
// sdi_fifo.v: small synchronous fifo with valid/ready on both sides
// assumes: single clock; width and depth set by parameters, depth a power of two
`timescale 1ns/1ps
module sdi_fifo #(
  parameter W = 14,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg out_full;
  wire push;
  wire pop;
  wire load;
  wire [AW:0] used;

  // the output register is one of the DEPTH words, so the memory never fills past DEPTH-1
  assign used = count + {{AW{1'b0}}, out_full};
  assign in_ready = (used < DEPTH);
  assign push = in_valid && in_ready;
  // output register holds the head word; refill when empty or taken
  assign out_valid = out_full;
  assign pop = out_full && out_ready;
  assign load = (count != {(AW+1){1'b0}}) && (!out_full || pop);

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      out_data <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        out_data <= mem[rd_ptr];
        rd_ptr <= rd_ptr + 1'b1;
        out_full <= 1'b1;
      end else if (pop) begin
        out_full <= 1'b0;
      end
      if (push && !load) begin
        count <= count + 1'b1;
      end else if (load && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ===== sdi_top.v
// sdi_top.v: three-wire serial input logic of a 12-bit voltage-output converter
// assumes: frame select, shift clock and data are pins, sampled by clk (200 MHz);
// shift clock phases each longer than the 5 ns clk period, the least the sampling can resolve.
// Behaviour
// [R1] a falling edge on the active-low frame select starts a new capture
// [R2] while selected, data is sampled on each shift clock falling edge
// [R3] the 16th falling edge completes the frame and applies it at once
// [R4] after applying, select may stay low or rise with no further effect
// [R5] master holds select high at least 33 ns between frames
// [R6] only a high-to-low select transition starts a frame
// [R7] master may idle select low between frames to save power
// [R8] the 12-bit code is straight unsigned binary, 0 to 4095
// [R9] frame: two ignored bits, mode high, mode low, twelve code bits msb first
// [R10] select rising before the 16th edge discards the frame entirely
// [R11] reset clears the code register until a complete frame arrives
// [R12] mode 00 normal, 01 1k to ground, 10 100k to ground, 11 high-z
// [R13] master sends msb first, may split frame in two bytes under select
`timescale 1ns/1ps
`include "sdi_regs.vh"
module sdi_top (
  // clock and reset
  input wire clk,
  input wire srst,
  // serial pins
  input wire sync_n,
  input wire sclk,
  input wire din,
  // converter controls
  output reg [`SDI_CODE_W-1:0] code,
  output reg [1:0] power_mode,
  output wire amp_enable,
  output wire out_gnd_1k,
  output wire out_gnd_100k,
  output wire out_hiz,
  // applied frame stream
  output wire frame_valid,
  input wire frame_ready,
  output wire [`SDI_FIFO_W-1:0] frame_data,
  output reg frame_aborted,
  output reg frame_dropped
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] shreg;
  reg [`SDI_CNT_W-1:0] bit_cnt;
  reg sync_q;
  reg sclk_q;
  wire [2:0] pins_s;
  wire sync_s;
  wire sclk_s;
  wire din_s;
  wire sync_fall;
  wire sync_rise;
  wire sclk_fall;
  wire last_bit;
  wire [15:0] full_frame;
  wire apply;
  wire fifo_in_ready;

  // mode decode, used for every analog switch control
  function mode_is;
    input [1:0] m;
    input [1:0] want;
    begin
      mode_is = (m == want);
    end
  endfunction

  sdi_sync2 #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in({sync_n, sclk, din}),
    .sync_out(pins_s)
  );

  assign sync_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];

  always @(posedge clk) begin
    if (srst) begin
      // matches the synchroniser's reset level, so release never looks like a select fall
      sync_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      sync_q <= sync_s;
      sclk_q <= sclk_s;
    end
  end

  assign sync_fall = sync_q && !sync_s; // R6
  assign sync_rise = !sync_q && sync_s;
  assign sclk_fall = sclk_q && !sclk_s; // R2
  assign last_bit = (bit_cnt == (`SDI_FRAME_BITS - 1));
  assign full_frame = {shreg[14:0], din_s};
  // select may rise right at the 16th fall; both arrive in one sample and the frame still counts
  assign apply = (state == ST_SHIFT) && sclk_fall && last_bit; // R3

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sync_fall) begin
          next_state = ST_SHIFT; // R1
        end
      end
      ST_SHIFT: begin
        if (apply) begin
          next_state = ST_DONE; // R4
        end else if (sync_s) begin
          next_state = ST_IDLE; // R10
        end
      end
      ST_DONE: begin
        // stays here while select is low; only a rise rearms
        if (sync_s) begin
          next_state = ST_IDLE; // R4
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      shreg <= 16'h0000;
      bit_cnt <= 5'h00;
      frame_aborted <= 1'b0;
    end else begin
      state <= next_state;
      frame_aborted <= (state == ST_SHIFT) && sync_rise && !apply; // R10
      if (state == ST_IDLE && sync_fall) begin
        shreg <= 16'h0000; // R1
        bit_cnt <= 5'h00;
      end else if (state == ST_SHIFT && sync_s && !apply) begin
        shreg <= 16'h0000; // R10
        bit_cnt <= 5'h00;
      end else if (state == ST_SHIFT && sclk_fall) begin
        shreg <= full_frame; // R2
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // code and mode are applied together, straight from the completed frame
  always @(posedge clk) begin
    if (srst) begin
      code <= `SDI_CODE_RESET; // R11
      power_mode <= `SDI_MODE_RESET;
    end else if (apply) begin
      code <= full_frame[`SDI_CODE_MSB:`SDI_CODE_LSB]; // R8 R9
      power_mode <= {full_frame[`SDI_MODE_HI_POS], full_frame[`SDI_MODE_LO_POS]}; // R9
    end
  end

  // a power-down frame still loads code like any other frame; the mode drives only the output stage
  assign amp_enable = mode_is(power_mode, `SDI_MODE_NORMAL); // R12
  assign out_gnd_1k = mode_is(power_mode, `SDI_MODE_GND_1K); // R12
  assign out_gnd_100k = mode_is(power_mode, `SDI_MODE_GND_100K); // R12
  assign out_hiz = mode_is(power_mode, `SDI_MODE_HIZ); // R12

  // applied frames are logged; a full log never blocks the converter update
  always @(posedge clk) begin
    if (srst) begin
      frame_dropped <= 1'b0;
    end else begin
      frame_dropped <= apply && !fifo_in_ready;
    end
  end

  sdi_fifo #(
    .W(`SDI_FIFO_W),
    .DEPTH(`SDI_FIFO_DEPTH),
    .AW(`SDI_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(apply),
    .in_ready(fifo_in_ready),
    .in_data(full_frame[13:0]),
    .out_valid(frame_valid),
    .out_ready(frame_ready),
    .out_data(frame_data)
  );
endmodule

// ===== sdi_top_chk.sv
// sdi_top_chk.sv: concurrent checks on the ports of the serial converter input block
// assumes: bound into sdi_top; a single clk domain with synchronous srst
`timescale 1ns/1ps
module sdi_top_chk (
  // clock and reset
  input wire clk,
  input wire srst,
  // pins and converter controls
  input wire sync_n,
  input wire [11:0] code,
  input wire [1:0] power_mode,
  input wire amp_enable,
  input wire out_gnd_1k,
  input wire out_gnd_100k,
  input wire out_hiz,
  // frame log
  input wire frame_valid,
  input wire frame_ready,
  input wire [13:0] frame_data,
  input wire frame_aborted,
  input wire frame_dropped
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // eight idle cycles outlast the sync and apply latency, so nothing may land
  sequence sel_idle;
    sync_n [*8];
  endsequence
  sequence head_held;
    frame_valid && !frame_ready;
  endsequence
  reset_clear_a: assert property ($fell(srst) |-> code == 12'h000 && power_mode == 2'h0 && !frame_valid)
    else $error("outputs not cleared by reset");
  mode_decode_a: assert property ({amp_enable, out_gnd_1k, out_gnd_100k, out_hiz} == (4'h8 >> power_mode))
    else $error("mode decode wrong");
  idle_stable_a: assert property (sel_idle |=> $stable(code) && $stable(power_mode))
    else $error("update while select high");
  abort_keep_a: assert property (frame_aborted |=> ($stable(code) && $stable(power_mode)) [*4])
    else $error("aborted frame applied");
  abort_pulse_a: assert property (frame_aborted |=> !frame_aborted)
    else $error("abort pulse too long");
  drop_full_a: assert property (frame_dropped |-> frame_valid ##1 !frame_dropped)
    else $error("drop pulse wrong");
  head_hold_a: assert property (head_held |=> frame_valid && $stable(frame_data))
    else $error("fifo head not held");
  log_match_a: assert property ($rose(frame_valid) |-> frame_data == {power_mode, code})
    else $error("logged frame differs");
endmodule

bind sdi_top sdi_top_chk i_sdi_top_chk (.clk(clk), .srst(srst), .sync_n(sync_n), .code(code),
  .power_mode(power_mode), .amp_enable(amp_enable), .out_gnd_1k(out_gnd_1k), .out_gnd_100k(out_gnd_100k),
  .out_hiz(out_hiz), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data),
  .frame_aborted(frame_aborted), .frame_dropped(frame_dropped));

// ===== sdi_master.sv
// sdi_master.sv: behavioural serial master driving select, shift clock and data
// assumes: 64 ns shift clock, idling high; caller waits for each transfer to return
`timescale 1ns/1ps
module sdi_master (
  // serial pins
  output logic sync_n,
  output logic sclk,
  output logic din
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // n frame bits, then extra falls with select still low; negative extra lifts select on the last fall
  task xfer(input logic [15:0] w, input int n, input int extra);
    int i;
    sync_n = 1'b1;
    #40;
    sync_n = 1'b0;
    for (i = 0; i < n + ((extra > 0) ? extra : 0); i++) begin
      din = (i < 16) ? w[15 - i] : ~w[i - 16];
      #32 sclk = 1'b0;
      if (extra < 0 && i == n - 1) sync_n = 1'b1;
      #32 sclk = 1'b1;
    end
    #32;
    // data released: show the inverse so a stale bit never looks valid
    din = ~din;
    // early rise cuts the frame; a full frame leaves select idling low unless extra is negative
    if (n < 16) sync_n = 1'b1;
  endtask
endmodule

// ===== sdi_top_tb.sv
// sdi_top_tb.sv: self-checking bench for the serial converter input block
// assumes: sdi_master drives the pins; consumer stalls until the drain scenario
`timescale 1ns/1ps
module sdi_top_tb;
  logic clk, srst, frame_ready;
  wire sync_n, sclk, din, amp_enable, out_gnd_1k, out_gnd_100k, out_hiz, frame_valid, frame_aborted, frame_dropped;
  wire [11:0] code;
  wire [1:0] power_mode;
  wire [13:0] frame_data;
  int n_mismatch = 0, total_checks = 0, n_ab = 0, n_dr = 0, cyc = 0;
  logic [13:0] exp = 14'h0000;
  logic [13:0] q[$];
  sdi_master i_sdi_master (.sync_n(sync_n), .sclk(sclk), .din(din));
  sdi_top i_sdi_top (.clk(clk), .srst(srst), .sync_n(sync_n), .sclk(sclk), .din(din), .code(code),
    .power_mode(power_mode), .amp_enable(amp_enable), .out_gnd_1k(out_gnd_1k), .out_gnd_100k(out_gnd_100k),
    .out_hiz(out_hiz), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data),
    .frame_aborted(frame_aborted), .frame_dropped(frame_dropped));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (frame_aborted === 1'b1) n_ab++;
    if (frame_dropped === 1'b1) n_dr++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task chk(input string what, input logic [15:0] e, input logic [15:0] got);
    total_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask
  // send, let the apply latency pass, then compare against the model
  task send(input logic [15:0] w, input int n, input int extra);
    i_sdi_master.xfer(w, n, extra);
    repeat (8) @(posedge clk);
    #1;
    if (n == 16) begin
      exp = w[13:0];
      if (q.size() < 8) q.push_back(w[13:0]);
    end
    chk("code", exp[11:0], code);
    chk("mode", exp[13:12], power_mode);
    chk("decode", 4'h8 >> exp[13:12], {amp_enable, out_gnd_1k, out_gnd_100k, out_hiz});
  endtask
  task s_reset;
    chk("reset code", 0, code);
    chk("reset mode", 0, power_mode);
  endtask
  task s_modes;
    logic [11:0] vals[4] = '{12'hFFF, 12'h000, 12'hA5C, 12'h001};
    for (int m = 0; m < 4; m++) send({2'b11, m[1:0], vals[m]}, 16, 0);
  endtask
  task s_abort;
    int a0;
    a0 = n_ab;
    send(16'h3123, 15, 0);
    send(16'h3123, 1, 0);
    chk("aborts", a0 + 2, n_ab);
  endtask
  task s_fifo;
    int k;
    for (int i = 0; i < 4; i++) send(16'h1000 + i, 16, 0);
    chk("drops", 1, n_dr);
    for (int i = 0; i < 8; i++) begin
      for (k = 0; k < 20 && frame_valid !== 1'b1; k++) @(posedge clk) #1;
      chk("log", q[i], frame_data);
      frame_ready = 1'b1;
      @(posedge clk) #1 frame_ready = 1'b0;
    end
    repeat (3) @(posedge clk);
    chk("empty", 0, frame_valid);
  endtask
  initial begin
    srst = 1'b1;
    frame_ready = 1'b0;
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    s_reset();
    s_modes();
    s_abort();
    send(16'h2ABC, 16, 16);
    s_fifo();
    send(16'h0DEF, 16, -1);
    end_of_test();
  end
endmodule
